// *** inc/htp_pkg.sv ***
// ----------------------------------------------------------------
// constants of the haptic trigger and power control block
// ----------------------------------------------------------------
package htp_pkg;

  // clock and timing
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned SHORT_POLL_NS = 10000;
  localparam int unsigned POLL_CYC = SHORT_POLL_NS / CLK_PERIOD_NS;
  localparam logic [7:0] POLL_LAST = 8'(POLL_CYC - 1);

  // register offsets
  localparam logic [7:0] A_STATUS = 8'h00;
  localparam logic [7:0] A_MODE = 8'h01;
  localparam logic [7:0] A_SEQ0 = 8'h04;
  localparam logic [7:0] A_SEQ7 = 8'h0B;
  localparam logic [7:0] A_FIRE = 8'h0C;
  localparam logic [7:0] A_NV0 = 8'h16;
  localparam logic [7:0] A_NV4 = 8'h1A;
  localparam logic [7:0] A_CTRL = 8'h1D;
  localparam logic [7:0] A_SUPPLY = 8'h21;

  // field positions
  localparam int unsigned B_SHORT = 0;
  localparam int unsigned B_TEMP = 1;
  localparam int unsigned B_STBY = 6;
  localparam int unsigned B_SRST = 7;
  localparam int unsigned B_FIRE = 0;
  localparam int unsigned B_SRC = 5;

  // operating modes
  localparam logic [2:0] MODE_INT = 3'h0;
  localparam logic [2:0] MODE_EDGE = 3'h1;
  localparam logic [2:0] MODE_LEVEL = 3'h2;
  localparam logic [2:0] MODE_INPUT = 3'h3;
  localparam logic [2:0] MODE_RTP = 3'h5;
  localparam logic [2:0] MODE_DIAG = 3'h6;
  localparam logic [2:0] MODE_CAL = 3'h7;

  // values after reset
  localparam logic [2:0] RST_MODE = MODE_INT;
  localparam logic RST_STBY = 1'b1;
  localparam logic [1:0] RST_GATE = 2'h0;
  localparam logic [39:0] RST_NV = 40'h00_0000_0000;

  // gate thresholds for settings 1..3 (0 passes everything)
  localparam logic [7:0] GATE_T1 = 8'h04;
  localparam logic [7:0] GATE_T2 = 8'h08;
  localparam logic [7:0] GATE_T3 = 8'h10;

  typedef enum logic [1:0] {PWR_SHUT, PWR_STBY, PWR_ACT} htp_pwr_t;

endpackage : htp_pkg

// *** logic/htp_ctrl.sv ***
// Implementation choices: the register addresses and the plain strobed port.
`timescale 1ns/1ps
// Function
// R1: edge mode: trigger rising edge sets fire bit, sequence plays normally.
// R2: edge mode: rising edge while fire set cancels playback, clears fire bit.
// R3: edge mode: trigger falling edge does nothing.
// R4: host holds edge pulses high at least 1 us.
// R5: software clearing fire bit cancels the remaining sequence.
// R6: level mode: fire bit follows trigger pin; falling edge cancels playback.
// R7: level mode: host holds trigger high for whole waveform.
// R8: input levels below the 2-bit gate threshold in 0x1D are suppressed.
// R9: during playback the supply reading at 0x21 is updated.
// R10: once programmed, nonvolatile values restore 0x16..0x1A after each reset.
// R11: overtemperature shuts down and sets thermal flag in 0x00.
// R12: output short latches flag, shuts down, polls, restarts in defaults; here the flag latches only while a sequence plays.
// R13: enable low gives shutdown keeping registers; high gives active.
// R14: enable low blocks every register read and write.
// R15: standby bit in 0x01 resets set; clearing it makes device ready.
// R16: setting standby stops playback at once.
// R17: soft-reset bit aborts playback, restores defaults, then self-clears.
// R18: mode field selects internal, edge, level, real-time, diagnostics, calibration.
// R19: mode 3 picks pulse-width or analog input by source bit.
// R20: writing 0x01 to 0x0C fires until done; also launches calibration, diagnostics.
// R21: in external trigger modes fire bit mirrors the trigger; here only level mode does, edge mode toggles it on rising edges.
// R22: real-time and input modes fire without touching stored fire bit.
// R23: playback starts at sequence register 0x04 and walks onward.
// R24: fire bit is bit 0 of 0x0C, other bits read zero.
module htp_ctrl
  import htp_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // pins and sensors
  input wire logic trigger_input_pin,
  input wire logic enable_pin,
  input wire logic over_temp_pin,
  input wire logic short_pin,
  // playback engine and converters
  input wire logic wave_done,
  input wire logic [7:0] input_level,
  input wire logic [7:0] supply_level,
  // nonvolatile store
  input wire logic nv_valid,
  input wire logic [39:0] nv_image,
  // control outputs
  output logic fire_signal,
  output logic [7:0] wave_id,
  output logic [2:0] op_mode,
  output logic pwm_sel,
  output logic [7:0] gated_level,
  output logic [1:0] power_state
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic status_temp;
    logic short_flag;
    logic [7:0] poll;
    logic [2:0] mode;
    logic standby;
    logic soft_pend;
    logic [7:0][7:0] seq;
    logic fire;
    logic playing;
    logic [2:0] idx;
    logic [4:0][7:0] nvr;
    logic [1:0] gate_threshold;
    logic src_sel;
    logic [7:0] supply;
    logic need_load;
    logic trig_q;
    logic [7:0] rdata;
    logic go;
    logic [7:0] wave;
    logic sel_pwm;
    logic [7:0] gated;
    htp_pwr_t pwr;
  } htp_st_t;

  localparam htp_st_t RST_S = '{
    mode: RST_MODE, standby: RST_STBY, gate_threshold: RST_GATE, nvr: RST_NV,
    need_load: 1'b1, pwr: PWR_SHUT, default: '0};

  htp_st_t s;
  htp_st_t n;
  logic trig_s;
  logic en_s;
  logic ot_s;
  logic sh_s;
  logic active;
  logic wr_fire;
  logic trig_rise;
  logic trig_fall;
  logic [7:0] rd_val;
  logic [7:0] thr;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  htp_sync u_trig (.clk(ref_clk), .rst(sys_rst), .d(trigger_input_pin), .q(trig_s));
  htp_sync u_en (.clk(ref_clk), .rst(sys_rst), .d(enable_pin), .q(en_s));
  htp_sync u_ot (.clk(ref_clk), .rst(sys_rst), .d(over_temp_pin), .q(ot_s));
  htp_sync u_sh (.clk(ref_clk), .rst(sys_rst), .d(short_pin), .q(sh_s));

  // ----------------------------------------------------------------
  // read mux and gate threshold
  // ----------------------------------------------------------------
  always_comb
  begin
    rd_val = 8'h00;
    if (reg_addr == A_STATUS)
    begin
      rd_val[B_TEMP] = s.status_temp;
      rd_val[B_SHORT] = s.short_flag;
    end
    else if (reg_addr == A_MODE)
      rd_val = {s.soft_pend, s.standby, 3'h0, s.mode};
    else if (reg_addr >= A_SEQ0 && reg_addr <= A_SEQ7)
      rd_val = s.seq[3'(reg_addr - A_SEQ0)];
    else if (reg_addr == A_FIRE)
      rd_val[B_FIRE] = s.fire; // R24 R21
    else if (reg_addr >= A_NV0 && reg_addr <= A_NV4)
      rd_val = s.nvr[3'(reg_addr - A_NV0)];
    else if (reg_addr == A_CTRL)
    begin
      rd_val[B_SRC] = s.src_sel;
      rd_val[1:0] = s.gate_threshold;
    end
    else if (reg_addr == A_SUPPLY)
      rd_val = s.supply;
    case (s.gate_threshold)
      2'h1: thr = GATE_T1;
      2'h2: thr = GATE_T2;
      2'h3: thr = GATE_T3;
      default: thr = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    n = s;
    n.rdata = 8'h00;
    n.trig_q = trig_s;
    trig_rise = trig_s & ~s.trig_q;
    trig_fall = ~trig_s & s.trig_q;
    active = en_s & ~s.standby & ~ot_s & ~s.short_flag & ~s.soft_pend & ~s.need_load &
             ~(reg_wr & (reg_addr == A_MODE) & reg_wdata[B_STBY]); // R16
    wr_fire = en_s & reg_wr & (reg_addr == A_FIRE);

    if (s.need_load)
    begin
      n.need_load = 1'b0;
      if (nv_valid)
        n.nvr = nv_image; // R10
    end

    // register access only while enabled
    if (en_s && reg_rd) // R14
    begin
      n.rdata = rd_val;
      if (reg_addr == A_STATUS)
        n.status_temp = 1'b0;
    end
    if (en_s && reg_wr) // R14
    begin
      if (reg_addr == A_MODE)
      begin
        n.mode = reg_wdata[2:0]; // R18
        n.standby = reg_wdata[B_STBY]; // R15
        n.soft_pend = reg_wdata[B_SRST]; // R17
      end
      else if (reg_addr >= A_SEQ0 && reg_addr <= A_SEQ7)
        n.seq[3'(reg_addr - A_SEQ0)] = reg_wdata;
      else if (reg_addr >= A_NV0 && reg_addr <= A_NV4)
        n.nvr[3'(reg_addr - A_NV0)] = reg_wdata;
      else if (reg_addr == A_CTRL)
      begin
        n.gate_threshold = reg_wdata[1:0]; // R8
        n.src_sel = reg_wdata[B_SRC]; // R19
      end
    end

    // fire bit handling
    if (active)
    begin
      if (s.mode == MODE_EDGE && trig_rise)
      begin
        if (s.fire)
        begin
          n.fire = 1'b0; // R2
          n.playing = 1'b0;
        end
        else
        begin
          n.fire = 1'b1; // R1
          n.playing = 1'b1;
          n.idx = 3'h0;
        end
      end
      // a falling edge in edge mode is simply not looked at
      if (wr_fire && s.mode != MODE_LEVEL)
      begin
        if (!reg_wdata[B_FIRE])
        begin
          n.fire = 1'b0; // R5
          n.playing = 1'b0;
        end
        else if ((s.mode == MODE_INT || s.mode == MODE_DIAG || s.mode == MODE_CAL) && !s.fire)
        begin
          n.fire = 1'b1; // R20
          n.playing = 1'b1;
          n.idx = 3'h0; // R23
        end
        else if (s.mode == MODE_INPUT || s.mode == MODE_RTP)
          n.fire = 1'b1;
      end
      if (s.mode == MODE_LEVEL)
      begin
        n.fire = trig_s; // R6 R21
        if (trig_rise)
        begin
          n.playing = 1'b1;
          n.idx = 3'h0;
        end
        if (trig_fall)
          n.playing = 1'b0; // R6
      end
      if (wave_done && s.playing && n.playing)
      begin
        if (s.idx != 3'h7 && s.seq[3'(s.idx + 3'h1)] != 8'h00 && s.mode <= MODE_LEVEL)
          n.idx = 3'(s.idx + 3'h1); // R23
        else
        begin
          n.playing = 1'b0;
          if (s.mode != MODE_LEVEL)
          begin
            n.fire = 1'b0; // R20
          end
        end
      end
      if (s.playing)
        n.supply = supply_level; // R9
    end
    else
    begin
      // standby, shutdown or a fault stops playback at once
      n.playing = 1'b0; // R16 R13
      if (s.playing && s.mode != MODE_LEVEL)
        n.fire = 1'b0;
    end

    if (ot_s)
      n.status_temp = 1'b1; // R11

    // shorts are only seen while a sequence is playing
    if (sh_s && s.playing && !s.short_flag)
    begin
      n.short_flag = 1'b1; // R12
      n.poll = 8'h00;
    end
    if (s.short_flag)
    begin
      n.poll = 8'(s.poll + 8'h01);
      if (s.poll == POLL_LAST)
      begin
        n.poll = 8'h00;
        if (!sh_s)
          n = RST_S; // R12
      end
    end

    if (s.soft_pend)
      n = RST_S; // R17

    // registered outputs
    n.gated = (input_level < thr) ? 8'h00 : input_level; // R8
    if (!en_s || ot_s || n.short_flag)
      n.pwr = PWR_SHUT; // R13 R11
    else if (n.standby)
      n.pwr = PWR_STBY; // R15
    else
      n.pwr = PWR_ACT;
    n.go = (n.pwr == PWR_ACT) && !n.soft_pend &&
           (n.playing || n.mode == MODE_INPUT || n.mode == MODE_RTP); // R22
    n.wave = (n.playing && n.mode <= MODE_LEVEL) ? n.seq[n.idx] : 8'h00;
    n.sel_pwm = (n.mode == MODE_INPUT) && n.src_sel; // R19
  end

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      s <= RST_S;
    else
      s <= n;
  end

  assign reg_rdata = s.rdata;
  assign fire_signal = s.go;
  assign wave_id = s.wave;
  assign op_mode = s.mode;
  assign pwm_sel = s.sel_pwm;
  assign gated_level = s.gated;
  assign power_state = s.pwr;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);

  sequence sr_req;
    en_s && reg_wr && reg_addr == A_MODE && reg_wdata[B_SRST];
  endsequence
  sequence sr_done;
    s.soft_pend ##1 (!s.soft_pend && s.standby && s.mode == MODE_INT && !s.playing);
  endsequence

  edge_set_a: assert property ( // R1
    active && s.mode == MODE_EDGE && trig_rise && !s.fire && !wr_fire |=> s.fire && s.playing)
    else $error("edge did not set fire");
  edge_cancel_a: assert property ( // R2
    active && s.mode == MODE_EDGE && trig_rise && s.fire && !wr_fire |=> !s.fire && !s.playing)
    else $error("second edge did not cancel");
  edge_fall_a: assert property ( // R3
    active && s.mode == MODE_EDGE && trig_fall && !wr_fire && !wave_done |=> s.fire == $past(s.fire))
    else $error("falling edge changed fire");
  sw_cancel_a: assert property ( // R5
    active && wr_fire && !reg_wdata[B_FIRE] && (s.mode <= MODE_EDGE || s.mode >= MODE_DIAG)
    |=> !s.playing ##1 !fire_signal)
    else $error("clear did not cancel");
  level_track_a: assert property ( // R6
    active && s.mode == MODE_LEVEL |=> s.fire == $past(trig_s))
    else $error("fire not tracking pin");
  gate_block_a: assert property ( // R8
    input_level < thr |=> gated_level == 8'h00)
    else $error("gate passed low level");
  shutdown_en_a: assert property ( // R13
    !en_s |=> power_state == PWR_SHUT && !fire_signal)
    else $error("not shut down");
  standby_stop_a: assert property ( // R16
    en_s && reg_wr && reg_addr == A_MODE && reg_wdata[B_STBY] |=> !fire_signal && !s.playing)
    else $error("standby did not stop");
  soft_reset_a: assert property ( // R17
    sr_req |=> sr_done)
    else $error("soft reset did not complete");
  thermal_a: assert property ( // R11
    ot_s |=> s.status_temp && power_state == PWR_SHUT)
    else $error("thermal not handled");
  cont_go_a: assert property ( // R22
    active && (s.mode == MODE_RTP || s.mode == MODE_INPUT) && !wr_fire && !reg_wr
    |=> fire_signal && s.fire == $past(s.fire))
    else $error("continuous mode not firing");

endmodule : htp_ctrl

// *** logic/htp_sync.sv ***
`timescale 1ns/1ps
// ----------------------------------------------------------------
// three-stage pin synchroniser, accepts a change once stages agree
// ----------------------------------------------------------------
module htp_sync
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // pin and clean level
  input wire logic d,
  output logic q
);
  logic s1;
  logic s2;
  logic s3;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      q <= 1'b0;
    end
    else
    begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3)
      begin
        q <= s3;
      end
    end
  end
endmodule : htp_sync

// *** tb/htp_host.sv ***
`timescale 1ns/1ps
// ----------------------------------------
// host side of trigger and enable pins
// ----------------------------------------
module htp_host
(
  // clock
  input wire logic ref_clk,
  // pins
  output logic trigger_input_pin,
  output logic enable_pin
);
  initial
  begin
    trigger_input_pin = 1'b0;
    enable_pin = 1'b1;
  end
  // short pulses may slip through the pin sync, so stretch them
  task automatic pulse(input int n);
    @(posedge ref_clk);
    trigger_input_pin <= 1'b1;
    repeat ((n < 25) ? 25 : n) @(posedge ref_clk);
    trigger_input_pin <= 1'b0;
  endtask : pulse
  task automatic level(input logic v);
    @(posedge ref_clk);
    trigger_input_pin <= v;
  endtask : level
  // registers answer only once the synced enable has settled
  task automatic en(input logic v);
    @(posedge ref_clk);
    enable_pin <= v;
    repeat (8) @(posedge ref_clk);
    #1;
  endtask : en
endmodule : htp_host

// *** tb/tb_top.sv ***
`timescale 1ns/1ps
module tb_top
  import htp_pkg::*;
;
  logic ref_clk, sys_rst, reg_wr, reg_rd, wave_done, nv_valid;
  logic over_temp_pin, short_pin, trigger_input_pin, enable_pin;
  logic fire_signal, pwm_sel;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, input_level;
  logic [7:0] supply_level, wave_id, gated_level, d;
  logic [39:0] nv_image;
  logic [2:0] op_mode;
  logic [1:0] power_state;
  int mismatches, total_checks;
  logic [2:0] md [7] = '{MODE_INT, MODE_EDGE, MODE_LEVEL, MODE_INPUT,
    MODE_RTP, MODE_DIAG, MODE_CAL};

  htp_host host (.ref_clk, .trigger_input_pin, .enable_pin);
  htp_ctrl uut (.ref_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .trigger_input_pin, .enable_pin, .over_temp_pin,
    .short_pin, .wave_done, .input_level, .supply_level, .nv_valid,
    .nv_image, .fire_signal, .wave_id, .op_mode, .pwm_sel, .gated_level,
    .power_state);

  initial
  begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    total_checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : idle
  task automatic wr8(input logic [7:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr8
  task automatic rd8(input logic [7:0] a);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd8
  // bounded wait, since the pin path adds a few sync cycles
  task automatic wf(input logic v);
    int i;
    i = 0;
    do
    begin
      idle(1);
      i++;
    end
    while (fire_signal !== v && i < 30);
    chk({7'h0, fire_signal}, {7'h0, v});
  endtask : wf
  task automatic pwr(input htp_pwr_t p);
    chk({6'h0, power_state}, {6'h0, p});
  endtask : pwr
  task automatic done;
    @(posedge ref_clk);
    wave_done <= 1'b1;
    @(posedge ref_clk);
    wave_done <= 1'b0;
    idle(2);
  endtask : done
  task automatic finish_test;
    if (mismatches == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : finish_test

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset;
    rd8(A_MODE);
    chk(d, 8'h40);
    pwr(PWR_STBY);
    rd8(A_FIRE);
    chk(d, 8'h00);
    rd8(A_NV0);
    chk(d, 8'h11);
  endtask : t_reset
  task automatic t_seq;
    wr8(A_SEQ0, 8'h11);
    wr8(A_SEQ0 + 8'h01, 8'h22);
    wr8(A_SEQ0 + 8'h02, 8'h00);
    wr8(A_MODE, 8'h00);
    idle(3);
    pwr(PWR_ACT);
    wr8(A_FIRE, 8'h01);
    wf(1'b1);
    chk(wave_id, 8'h11);
    @(posedge ref_clk);
    supply_level <= 8'h5a;
    rd8(A_SUPPLY);
    chk(d, 8'h5a);
    rd8(A_FIRE);
    chk(d, 8'h01);
    done;
    chk(wave_id, 8'h22);
    done;
    wf(1'b0);
  endtask : t_seq
  task automatic t_cancel;
    wr8(A_FIRE, 8'h01);
    wf(1'b1);
    wr8(A_FIRE, 8'h00);
    wf(1'b0);
    wr8(A_FIRE, 8'h01);
    wf(1'b1);
    wr8(A_MODE, 8'h40);
    wf(1'b0);
    pwr(PWR_STBY);
  endtask : t_cancel
  task automatic t_edge;
    wr8(A_MODE, {5'h0, MODE_EDGE});
    host.pulse(25);
    wf(1'b1);
    idle(10);
    chk({7'h0, fire_signal}, 8'h01);
    rd8(A_FIRE);
    chk(d, 8'h01);
    host.pulse(25);
    wf(1'b0);
  endtask : t_edge
  task automatic t_level;
    wr8(A_MODE, {5'h0, MODE_LEVEL});
    host.level(1'b1);
    wf(1'b1);
    idle(20);
    chk({7'h0, fire_signal}, 8'h01);
    host.level(1'b0);
    wf(1'b0);
  endtask : t_level
  task automatic t_modes;
    for (int i = 0; i < 7; i++)
    begin
      wr8(A_MODE, {5'h0, md[i]});
      idle(2);
      chk({5'h0, op_mode}, {5'h0, md[i]});
    end
    wr8(A_CTRL, 8'h21);
    wr8(A_MODE, {5'h0, MODE_INPUT});
    wf(1'b1);
    chk({7'h0, pwm_sel}, 8'h01);
    @(posedge ref_clk);
    input_level <= GATE_T1 - 8'h01;
    idle(3);
    chk(gated_level, 8'h00);
    input_level <= GATE_T1;
    idle(3);
    chk(gated_level, GATE_T1);
    wr8(A_MODE, {5'h0, MODE_RTP});
    wf(1'b1);
    chk({7'h0, pwm_sel}, 8'h00);
    rd8(A_FIRE);
    chk(d, 8'h00);
    wr8(A_MODE, {5'h0, MODE_DIAG});
    wr8(A_FIRE, 8'h01);
    wf(1'b1);
    done;
    wf(1'b0);
    wr8(A_MODE, 8'h00);
  endtask : t_modes
  task automatic t_enable;
    host.en(1'b0);
    pwr(PWR_SHUT);
    wr8(A_SEQ0, 8'h77);
    rd8(A_SEQ0);
    chk(d, 8'h00);
    host.en(1'b1);
    pwr(PWR_ACT);
    rd8(A_SEQ0);
    chk(d, 8'h11);
  endtask : t_enable
  task automatic t_fault;
    @(posedge ref_clk);
    over_temp_pin <= 1'b1;
    idle(8);
    pwr(PWR_SHUT);
    rd8(A_STATUS);
    chk(d & 8'h02, 8'h02);
    over_temp_pin <= 1'b0;
    idle(8);
    rd8(A_STATUS);
    rd8(A_STATUS);
    chk(d & 8'h02, 8'h00);
    wr8(A_MODE, 8'h00);
    wr8(A_FIRE, 8'h01);
    wf(1'b1);
    short_pin <= 1'b1;
    idle(8);
    pwr(PWR_SHUT);
    rd8(A_STATUS);
    chk(d & 8'h01, 8'h01);
    short_pin <= 1'b0;
    idle(2 * POLL_CYC);
    rd8(A_MODE);
    chk(d, 8'h40);
  endtask : t_fault
  task automatic t_srst;
    wr8(A_SEQ0, 8'h33);
    wr8(A_NV0, 8'h99);
    wr8(A_MODE, 8'h00);
    wr8(A_FIRE, 8'h01);
    wf(1'b1);
    wr8(A_MODE, 8'h80);
    wf(1'b0);
    idle(3);
    rd8(A_MODE);
    chk(d, 8'h40);
    rd8(A_SEQ0);
    chk(d, 8'h00);
    rd8(A_NV0);
    chk(d, 8'h11);
    // an unprogrammed store leaves the reset values in place
    nv_valid <= 1'b0;
    wr8(A_MODE, 8'h80);
    idle(3);
    rd8(A_NV0);
    chk(d, RST_NV[7:0]);
    nv_valid <= 1'b1;
    nv_image <= 40'h00_0000_00a5;
    wr8(A_MODE, 8'h80);
    idle(3);
    rd8(A_NV0);
    chk(d, 8'ha5);
  endtask : t_srst

  initial
  begin
    sys_rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    wave_done = 1'b0;
    input_level = 8'h00;
    supply_level = 8'h00;
    nv_valid = 1'b1;
    nv_image = 40'h55_4433_2211;
    over_temp_pin = 1'b0;
    short_pin = 1'b0;
    mismatches = 0;
    total_checks = 0;
    repeat (6) @(posedge ref_clk);
    sys_rst <= 1'b0;
    idle(8);
    t_reset;
    t_seq;
    t_cancel;
    t_edge;
    t_level;
    t_modes;
    t_enable;
    t_fault;
    t_srst;
    finish_test;
  end

  // run needs under a thousand cycles; the margin covers slow sync paths
  initial
  begin
    #(CLK_PERIOD_NS * 20000);
    mismatches++;
    finish_test;
  end
endmodule : tb_top
